// >>> core/efim_top.sv
// Interrupt mask, control word and receive code-detect logic of an E1 framer
`timescale 1ns/10ps
module efim_top
   import efim_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic rx_slot_valid,
   input wire logic [7:0] rx_slot_data,
   input wire logic slot_compare_select,
   input wire logic ev_sync_loss,
   input wire logic ev_remote_alarm,
   input wire logic ev_ais,
   input wire logic ev_ais16,
   input wire logic ev_signal_loss,
   input wire logic ev_frame_error,
   input wire logic ev_bpv,
   input wire logic ev_slip,
   input wire logic ev_remote_crc,
   input wire logic ev_local_crc,
   input wire logic ev_alarm_crc_inc,
   input wire logic ev_fas_bit_error,
   input wire logic ev_buffer_bit_error,
   input wire logic ev_abcd_change,
   output logic receive_delay_select,
   output logic tx_signalling_mode,
   output logic register_signalling_select,
   output logic bit_error_source_select,
   output logic bit_error_count,
   output logic [7:0] bit_error_counter,
   output logic irq_n_out,
   output logic irq_n_oe_n
);
   logic [7:0] match_pattern;
   logic [7:0] match_pattern_mask;
   logic [7:0] ctrl;
   logic [7:0] mask0;
   logic [7:0] mask1;
   logic [7:0] stat0;
   logic [7:0] stat1;
   logic match_flag;
   logic [15:0] bpv_count;
   logic prev_frame_error;
   logic [8:0] vector;
   logic [7:0] ev0;
   logic [7:0] ev1;
   logic [7:0] en0;
   logic [7:0] en1;
   logic bpv_wrap;
   logic cef_event;
   logic bit_err_event;
   logic match_event;
   logic suspend;
   logic pending;
   logic clr0;
   logic clr1;
   logic clrm;

   // Masked equality: only positions whose mask bit is one take part
   function automatic logic efim_masked_eq(input logic [7:0] a, input logic [7:0] b, input logic [7:0] m);
      efim_masked_eq = ((a ^ b) & m) == 8'h00;
   endfunction

   assign suspend = ctrl[EFIM_CTRL_SUSPEND];
   // Slot compare, MSB first matches register bit order directly
   assign match_event = rx_slot_valid && slot_compare_select &&
                        efim_masked_eq(rx_slot_data, match_pattern, match_pattern_mask);
   assign bpv_wrap = ev_bpv && (bpv_count == EFIM_BPV_MAX);
   assign cef_event = ev_frame_error && prev_frame_error;
   assign bit_err_event = ctrl[EFIM_CTRL_BERSRC] ? ev_buffer_bit_error : ev_fas_bit_error;

   // Event vectors laid out like the mask words
   assign ev0 = {ev_sync_loss, ev_remote_alarm, ev_ais, ev_ais16, ev_signal_loss,
                 ev_frame_error, bpv_wrap, ev_slip};
   assign ev1 = {ev_remote_crc, ev_local_crc, cef_event, ev_bpv, ev_alarm_crc_inc,
                 bit_err_event, 1'b0, ev_abcd_change};
   // Mask zero is active-high masking, mask one active-high enabling
   assign en0 = ~mask0;
   assign en1 = mask1 & EFIM_MASK1_USED;

   assign clr0 = wr && (addr == EFIM_ADDR_STAT0);
   assign clr1 = wr && (addr == EFIM_ADDR_STAT1);
   assign clrm = wr && (addr == EFIM_ADDR_MATCH);

   // Control registers written by software
   always_ff @(posedge clk) begin
      if (rst) begin
         match_pattern <= EFIM_RESET_VAL;
         match_pattern_mask <= EFIM_RESET_VAL;
         ctrl <= EFIM_RESET_VAL;
         mask0 <= EFIM_RESET_VAL;
         mask1 <= EFIM_RESET_VAL;
      end else if (wr) begin
         unique case (addr)
            EFIM_ADDR_PATTERN: match_pattern <= wdata;
            EFIM_ADDR_PMASK: match_pattern_mask <= wdata;
            EFIM_ADDR_CTRL: ctrl <= wdata & EFIM_CTRL_USED;
            EFIM_ADDR_MASK0: mask0 <= wdata;
            EFIM_ADDR_MASK1: mask1 <= wdata & EFIM_MASK1_USED;
            default: ;
         endcase
      end
   end

   // Sticky status; a new event wins over a write-one clear. Suspend drops sources.
   always_ff @(posedge clk) begin
      if (rst) begin
         stat0 <= EFIM_RESET_VAL;
         stat1 <= EFIM_RESET_VAL;
         match_flag <= 1'b0;
      end else begin
         stat0 <= ((clr0 ? stat0 & ~wdata : stat0) | (suspend ? 8'h00 : ev0 & en0));
         stat1 <= ((clr1 ? stat1 & ~wdata : stat1) | (suspend ? 8'h00 : ev1 & en1));
         match_flag <= ((clrm && wdata[0]) ? 1'b0 : match_flag) | (match_event && !suspend);
      end
   end

   // Violation counter and consecutive frame error history
   always_ff @(posedge clk) begin
      if (rst) begin
         bpv_count <= 16'h0000;
         prev_frame_error <= 1'b0;
      end else begin
         if (ev_bpv) begin
            bpv_count <= bpv_count + 16'h0001;
         end
         if (ev_frame_error || ev_fas_ok_frame()) begin
            prev_frame_error <= ev_frame_error;
         end
      end
   end

   // Frame boundary without error is not separately reported; history is cleared only by reset, as no error-free frame indication is available
   function automatic logic ev_fas_ok_frame();
      ev_fas_ok_frame = 1'b0;
   endfunction

   // Bit error counter driven from the selected source
   always_ff @(posedge clk) begin
      if (rst) begin
         bit_error_counter <= 8'h00;
         bit_error_count <= 1'b0;
      end else begin
         bit_error_count <= bit_err_event;
         if (bit_err_event) begin
            bit_error_counter <= bit_error_counter + 8'h01;
         end
      end
   end

   // Highest-priority pending vector for software
   always_comb begin
      vector = EFIM_VEC_NONE;
      if (stat0[EFIM_M0_SYNC]) vector = EFIM_VEC_SYNC;
      else if (|stat0[EFIM_M0_RAI:EFIM_M0_LOS]) vector = EFIM_VEC_ALARM;
      else if (stat0[EFIM_M0_FER]) vector = EFIM_VEC_FER;
      else if (|stat1[EFIM_M1_EBIT:EFIM_M1_BER]) vector = EFIM_VEC_ERR;
      else if (stat0[EFIM_M0_VIOLATION_OVERFLOW_MASK]) vector = EFIM_VEC_OVF;
      else if (stat0[EFIM_M0_SLIP]) vector = EFIM_VEC_SLIP;
      else if (match_flag) vector = EFIM_VEC_DATA;
      else if (stat1[EFIM_M1_SIG]) vector = EFIM_VEC_SIG;
   end

   assign pending = (|stat0) || (|stat1) || match_flag;

   // Read data one cycle after the strobe; unmapped reads return zero
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (rd) begin
         unique case (addr)
            EFIM_ADDR_PATTERN: rdata <= match_pattern;
            EFIM_ADDR_PMASK: rdata <= match_pattern_mask;
            EFIM_ADDR_CTRL: rdata <= ctrl;
            EFIM_ADDR_MASK0: rdata <= mask0;
            EFIM_ADDR_MASK1: rdata <= mask1;
            EFIM_ADDR_STAT0: rdata <= stat0;
            EFIM_ADDR_STAT1: rdata <= stat1;
            EFIM_ADDR_VECTOR: rdata <= vector[8:1];
            EFIM_ADDR_MATCH: rdata <= {7'h00, match_flag};
            default: rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   // Mode outputs and open-drain request; enable low means driving low
   always_ff @(posedge clk) begin
      if (rst) begin
         receive_delay_select <= 1'b0;
         tx_signalling_mode <= 1'b0;
         register_signalling_select <= 1'b0;
         bit_error_source_select <= 1'b0;
         irq_n_out <= 1'b1;
         irq_n_oe_n <= 1'b1;
      end else begin
         receive_delay_select <= ctrl[EFIM_CTRL_DELAY];
         tx_signalling_mode <= ctrl[EFIM_CTRL_TXSIG];
         register_signalling_select <= ctrl[EFIM_CTRL_REGSIG];
         bit_error_source_select <= ctrl[EFIM_CTRL_BERSRC];
         irq_n_out <= 1'b0;
         irq_n_oe_n <= !(pending && !suspend);
      end
   end
endmodule

// >>> core/efim_pkg.sv
// Package: register map, field positions, vectors and reset values for the E1 interrupt and code-detect block
package efim_pkg;
   localparam logic [7:0] EFIM_ADDR_PATTERN = 8'h18;
   localparam logic [7:0] EFIM_ADDR_PMASK = 8'h19;
   localparam logic [7:0] EFIM_ADDR_CTRL = 8'h1A;
   localparam logic [7:0] EFIM_ADDR_MASK0 = 8'h1B;
   localparam logic [7:0] EFIM_ADDR_MASK1 = 8'h1C;
   localparam logic [7:0] EFIM_ADDR_STAT0 = 8'h20;
   localparam logic [7:0] EFIM_ADDR_STAT1 = 8'h21;
   localparam logic [7:0] EFIM_ADDR_VECTOR = 8'h22;
   localparam logic [7:0] EFIM_ADDR_MATCH = 8'h23;
   localparam logic [7:0] EFIM_RESET_VAL = 8'h00;
   localparam logic [7:0] EFIM_CTRL_USED = 8'hDC;
   localparam logic [7:0] EFIM_MASK1_USED = 8'hFD;
   localparam int EFIM_CTRL_DELAY = 7;
   localparam int EFIM_CTRL_SUSPEND = 6;
   localparam int EFIM_CTRL_TXSIG = 4;
   localparam int EFIM_CTRL_REGSIG = 3;
   localparam int EFIM_CTRL_BERSRC = 2;
   localparam int EFIM_M0_SYNC = 7;
   localparam int EFIM_M0_RAI = 6;
   localparam int EFIM_M0_AIS = 5;
   localparam int EFIM_M0_AIS16 = 4;
   localparam int EFIM_M0_LOS = 3;
   localparam int EFIM_M0_FER = 2;
   localparam int EFIM_M0_VIOLATION_OVERFLOW_MASK = 1;
   localparam int EFIM_M0_SLIP = 0;
   localparam int EFIM_M1_EBIT = 7;
   localparam int EFIM_M1_CRC = 6;
   localparam int EFIM_M1_CEF = 5;
   localparam int EFIM_M1_BPV = 4;
   localparam int EFIM_M1_RCR = 3;
   localparam int EFIM_M1_BER = 2;
   localparam int EFIM_M1_SIG = 0;
   // Vector codes, nine bits so the widest printed code fits unchanged
   localparam logic [8:0] EFIM_VEC_NONE = 9'h000;
   localparam logic [8:0] EFIM_VEC_SYNC = 9'h100;
   localparam logic [8:0] EFIM_VEC_ALARM = 9'h040;
   localparam logic [8:0] EFIM_VEC_FER = 9'h040;
   localparam logic [8:0] EFIM_VEC_OVF = 9'h010;
   localparam logic [8:0] EFIM_VEC_ERR = 9'h020;
   localparam logic [8:0] EFIM_VEC_DATA = 9'h002;
   localparam logic [8:0] EFIM_VEC_SLIP = 9'h004;
   localparam logic [8:0] EFIM_VEC_SIG = 9'h001;
   localparam logic [15:0] EFIM_BPV_MAX = 16'hFFFF;
endpackage

// >>> verification/efim_host.sv
// Host-side view of the interrupt request wire, with its pull-up
`timescale 1ns/10ps
module efim_host (
   input wire logic irq_n_out,
   input wire logic irq_n_oe_n,
   output logic irq_line
);
   // Released wire floats up to the pull-up, so it never echoes the last driven level
   assign irq_line = irq_n_oe_n ? 1'b1 : irq_n_out;
endmodule

// >>> verification/efim_top_monitor.sv
// Port checker for the E1 interrupt and code-detect block
`timescale 1ns/10ps
module efim_top_monitor
   import efim_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic ev_fas_bit_error,
   input wire logic ev_buffer_bit_error,
   input wire logic receive_delay_select,
   input wire logic bit_error_source_select,
   input wire logic bit_error_count,
   input wire logic [7:0] bit_error_counter,
   input wire logic irq_n_out,
   input wire logic irq_n_oe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Bus answers: zero when idle, above the match address and on unused bits
   a_idle_read_zero: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("rdata not zero outside a read answer");
   a_hole_read_zero: assert property (rd && addr > EFIM_ADDR_MATCH |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_ctrl_unused_zero: assert property (rd && addr == EFIM_ADDR_CTRL |=> (rdata & ~EFIM_CTRL_USED) == 8'h00)
      else $error("unused control bits read back set");
   a_mask1_unused_zero: assert property (rd && addr == EFIM_ADDR_MASK1 |=> (rdata & ~EFIM_MASK1_USED) == 8'h00)
      else $error("unused mask one bit read back set");
   // Request wire: drive level and suspend release
   a_irq_level_low: assert property ($past(!rst) |-> !irq_n_out)
      else $error("interrupt drive level not low");
   a_suspend_releases: assert property (wr && addr == EFIM_ADDR_CTRL && wdata[EFIM_CTRL_SUSPEND] |-> ##2 irq_n_oe_n)
      else $error("suspend did not release the request");
   // Bit error counting follows the selected source; delay select moves only after a control write
   a_bit_err_source: assert property (bit_error_count |-> $past(bit_error_source_select ? ev_buffer_bit_error : ev_fas_bit_error))
      else $error("bit error counted from the wrong source");
   a_count_cause: assert property ($changed(bit_error_counter) |-> $past(ev_fas_bit_error | ev_buffer_bit_error) || $past(ev_fas_bit_error | ev_buffer_bit_error, 2))
      else $error("bit error counter moved without an error");
   a_delay_copy: assert property ($changed(receive_delay_select) |-> $past(wr && addr == EFIM_ADDR_CTRL) || $past(wr && addr == EFIM_ADDR_CTRL, 2))
      else $error("buffer length select changed without a write");
endmodule
bind efim_top efim_top_monitor mon_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .ev_fas_bit_error(ev_fas_bit_error), .ev_buffer_bit_error(ev_buffer_bit_error),
   .receive_delay_select(receive_delay_select), .bit_error_source_select(bit_error_source_select),
   .bit_error_count(bit_error_count), .bit_error_counter(bit_error_counter), .irq_n_out(irq_n_out), .irq_n_oe_n(irq_n_oe_n));

// >>> verification/efim_top_test.sv
// Self-checking bench for the E1 interrupt and code-detect block
`timescale 1ns/10ps
module efim_top_test;
   import efim_pkg::*;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} efim_row_t;
   logic clk = 0, rst = 1, wr = 0, rd = 0, rx_slot_valid = 0, slot_compare_select = 0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rx_slot_data = 8'h00, rdata, bit_error_counter;
   logic [13:0] ev = 14'h0000;
   logic rds, txm, rss, bes, bit_error_count, irq_n_out, irq_n_oe_n, irq_line;
   int miscompares = 0, check_count = 0;
   efim_row_t rows[6] = '{'{8'h18, 8'hA5, 8'hA5}, '{8'h19, 8'h3C, 8'h3C}, '{8'h1A, 8'hFF, 8'hDC},
      '{8'h1B, 8'hFF, 8'hFF}, '{8'h1C, 8'hFF, 8'hFD}, '{8'h30, 8'h77, 8'h00}};
   logic [7:0] vec0[8] = '{EFIM_VEC_SYNC[8:1], EFIM_VEC_ALARM[8:1], EFIM_VEC_ALARM[8:1], EFIM_VEC_ALARM[8:1],
      EFIM_VEC_ALARM[8:1], EFIM_VEC_FER[8:1], 8'h00, EFIM_VEC_SLIP[8:1]};
   int e1[7] = '{5, 4, 8, 7, 3, 2, 0};
   efim_top dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .rx_slot_valid(rx_slot_valid), .rx_slot_data(rx_slot_data), .slot_compare_select(slot_compare_select),
      .ev_sync_loss(ev[13]), .ev_remote_alarm(ev[12]), .ev_ais(ev[11]), .ev_ais16(ev[10]), .ev_signal_loss(ev[9]),
      .ev_frame_error(ev[8]), .ev_bpv(ev[7]), .ev_slip(ev[6]), .ev_remote_crc(ev[5]), .ev_local_crc(ev[4]),
      .ev_alarm_crc_inc(ev[3]), .ev_fas_bit_error(ev[2]), .ev_buffer_bit_error(ev[1]), .ev_abcd_change(ev[0]),
      .receive_delay_select(rds), .tx_signalling_mode(txm), .register_signalling_select(rss),
      .bit_error_source_select(bes), .bit_error_count(bit_error_count), .bit_error_counter(bit_error_counter),
      .irq_n_out(irq_n_out), .irq_n_oe_n(irq_n_oe_n));
   efim_host host_u (.irq_n_out(irq_n_out), .irq_n_oe_n(irq_n_oe_n), .irq_line(irq_line));
   // Free-running 100 MHz clock
   always #5 clk = ~clk;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Data stands only in the cycle after the strobe, so it is taken just after that edge
   task automatic rreg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   // Event held n cycles, then two cycles for status and request to land
   task automatic pev(input int i, input int n);
      @(posedge clk);
      ev[i] <= 1'b1;
      repeat (n) @(posedge clk);
      ev[i] <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic slot(input logic [7:0] d, input logic s, input logic [7:0] e);
      @(posedge clk);
      rx_slot_valid <= 1'b1;
      rx_slot_data <= d;
      slot_compare_select <= s;
      @(posedge clk);
      rx_slot_valid <= 1'b0;
      rreg(EFIM_ADDR_MATCH, e);
      wreg(EFIM_ADDR_MATCH, 8'h01);
   endtask
   task automatic conclude();
      $display("checks=%0d miscompares=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Watchdog sized above the long violation-counter run
   initial begin
      #900000;
      miscompares++;
      conclude();
   end
   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         wreg(rows[i].a, rows[i].d);
         rreg(rows[i].a, rows[i].e);
      end
      chk({rds, txm, rss, bes}, 8'h0F);
      $display("register table done");
      // Mid-run reset is raised on an edge like every other input
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) rreg(rows[i].a, 8'h00);
      chk({rds, txm, rss, bes, irq_line}, 8'h01);
      $display("reset done");
      wreg(EFIM_ADDR_PATTERN, 8'hA5);
      wreg(EFIM_ADDR_PMASK, 8'hF0);
      slot(8'hA3, 1'b1, 8'h01);
      slot(8'h53, 1'b1, 8'h00);
      slot(8'hA5, 1'b0, 8'h00);
      $display("pattern match done");
      for (int i = 0; i < 8; i++) begin
         if (i == 6) continue;
         pev(13 - i, 1);
         chk(irq_line, 1'b0);
         rreg(EFIM_ADDR_STAT0, 8'h80 >> i);
         rreg(EFIM_ADDR_VECTOR, vec0[i]);
         wreg(EFIM_ADDR_STAT0, 8'hFF);
         rreg(EFIM_ADDR_STAT0, 8'h00);
         chk(irq_line, 1'b1);
      end
      wreg(EFIM_ADDR_MASK0, 8'hFF);
      pev(6, 1);
      chk(irq_line, 1'b1);
      pev(5, 1);
      chk(irq_line, 1'b1);
      wreg(EFIM_ADDR_STAT1, 8'hFF);
      wreg(EFIM_ADDR_MASK1, 8'hFD);
      $display("mask word zero done");
      for (int i = 0; i < 7; i++) begin
         pev(e1[i], (e1[i] == 8) ? 2 : 1);
         chk(irq_line, 1'b0);
         rreg(EFIM_ADDR_STAT1, 8'h80 >> (i + (i == 6)));
         wreg(EFIM_ADDR_STAT1, 8'hFF);
      end
      pev(1, 1);
      chk(bit_error_counter, 8'h01);
      wreg(EFIM_ADDR_CTRL, 8'h04);
      pev(1, 1);
      chk(irq_line, 1'b0);
      chk(bit_error_counter, 8'h02);
      wreg(EFIM_ADDR_STAT1, 8'hFF);
      wreg(EFIM_ADDR_CTRL, 8'h40);
      pev(0, 1);
      chk(irq_line, 1'b1);
      rreg(EFIM_ADDR_STAT1, 8'h00);
      $display("mask word one and suspend done");
      wreg(EFIM_ADDR_CTRL, 8'h00);
      wreg(EFIM_ADDR_MASK1, 8'h00);
      wreg(EFIM_ADDR_STAT0, 8'hFF);
      wreg(EFIM_ADDR_MASK0, 8'hFD);
      pev(7, 65534);
      rreg(EFIM_ADDR_STAT0, 8'h00);
      pev(7, 1);
      chk(irq_line, 1'b0);
      rreg(EFIM_ADDR_STAT0, 8'h02);
      $display("violation wrap done");
      conclude();
   end
endmodule
